// File: shared/rmc_pkg.sv
// Package: register map, field positions, modes and bus carriers of the receiver mode block
`default_nettype none
package rmc_pkg;
    // Register indices and their word byte addresses
    localparam logic [11:0] RMC_IDX_CMD = 12'h0A4;
    localparam logic [11:0] RMC_IDX_CFG = 12'h0A5;
    localparam logic [11:0] RMC_ADDR_CMD = 12'(RMC_IDX_CMD << 2);
    localparam logic [11:0] RMC_ADDR_CFG = 12'(RMC_IDX_CFG << 2);
    // Reset values and writable masks
    localparam logic [7:0] RMC_CMD_RESET = 8'h00;
    localparam logic [7:0] RMC_CFG_RESET = 8'h04;
    localparam logic [7:0] RMC_CMD_MASK = 8'h0F;
    localparam logic [7:0] RMC_CFG_MASK = 8'h3F;
    // Command register fields
    localparam int RMC_B_GAIN_FRZ = 3;
    localparam int RMC_B_FREQ_FRZ = 2;
    localparam int RMC_B_FORCE_TMO = 1;
    localparam int RMC_B_FORCE_EOM = 0;
    // Configuration register fields
    localparam int RMC_B_CONT_MSG = 5;
    localparam int RMC_B_CONT_TMO = 4;
    localparam int RMC_B_CYC_INIT = 3;
    localparam int RMC_B_FRM_INIT = 2;
    localparam int RMC_B_LOCK = 1;
    localparam int RMC_B_XTAL = 0;
    // External processing selections that allow forcing
    localparam logic [1:0] RMC_EXT_SEL_A = 2'h1;
    localparam logic [1:0] RMC_EXT_SEL_B = 2'h2;
    // Operating mode of the receive sequencer
    typedef enum logic [2:0] {
        RMC_SLAVE = 3'h1,
        RMC_POLL = 3'h2,
        RMC_RUN = 3'h4
    } rmc_mode_t;
    // APB request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } rmc_apb_req_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rmc_apb_rsp_t;
    // Address decode: bit 1 configuration, bit 0 command
    function automatic logic [1:0] rmc_decode(input logic [11:0] addr);
        rmc_decode = {addr == RMC_ADDR_CFG, addr == RMC_ADDR_CMD};
    endfunction
endpackage
`default_nettype wire

// File: verilog/rmc_apb_slave.sv
// Module: APB handshake with one wait state and registered answer
`default_nettype none
module rmc_apb_slave import rmc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire rmc_apb_req_t req,
    input wire logic mapped,
    input wire logic [31:0] rd_data,
    output var rmc_apb_rsp_t rsp,
    output logic wr_go
);
    typedef struct packed {
        rmc_apb_rsp_t rsp;
    } rmc_slv_state_t;

    rmc_slv_state_t st;
    rmc_slv_state_t next_st;

    // First access cycle loads the answer, the next one completes it
    always_comb begin
        next_st = st;
        if (st.rsp.pready) begin
            next_st.rsp = '0;
        end else if (req.psel && req.penable) begin
            next_st.rsp.pready = 1'b1;
            next_st.rsp.pslverr = !mapped;
            next_st.rsp.prdata = req.pwrite ? 32'h0000_0000 : rd_data;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Write commits on the completing edge only
    assign wr_go = st.rsp.pready && req.psel && req.penable && req.pwrite && mapped;
    assign rsp = st.rsp;
endmodule
`default_nettype wire

// File: verilog/rmc_regs.sv
// Module: receiver command and mode control registers with polling sequencer
// Summary of operation
// - Software freeze bits freeze gain or frequency control when source is software.
// - Writing one to force-timeout pulses timeout only for external selection 1 or 2.
// - Writing one to force-end-of-message pulses it only for external selection 1 or 2.
// - After message end in polling run, resume polling: config A or next per bit 5.
// - After timeout in polling run, resume polling: config A or next per bit 4.
// - Cycle-start init bit clears receive FIFO when slave run begins.
// - Cycle-start init bit clears FIFO on wake-up entering polling run.
// - Frame-start init bit clears FIFO at every frame start; enabled after reset.
// - Lock bit locks FIFO and receive chain at message end until released.
// - Crystal bit selects high precision oscillator in sleep; off after reset.
// - Mode select 0 gives slave run or sleep, 1 gives self-polling.
`default_nettype none
module rmc_regs import rmc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire rmc_apb_req_t apb_req,
    output var rmc_apb_rsp_t apb_rsp,
    input wire logic operating_mode_select,
    input wire logic [1:0] external_processing_select,
    input wire logic gain_freeze_source_sw,
    input wire logic freq_freeze_source_sw,
    input wire logic end_of_message_in,
    input wire logic receive_timeout_in,
    input wire logic wakeup_found,
    input wire logic slave_run_start,
    input wire logic frame_start,
    input wire logic fifo_lock_release,
    output logic gain_freeze,
    output logic freq_freeze,
    output logic receive_timeout_force,
    output logic end_of_message_force,
    output logic resume_poll,
    output logic resume_next_config,
    output logic fifo_init,
    output logic fifo_lock,
    output logic rx_chain_lock,
    output logic crystal_precision_in_sleep
);
    typedef struct packed {
        rmc_mode_t mode;
        logic [1:0] man_freeze;
        logic [5:0] cfg;
        logic fifo_locked;
        logic gain_frz;
        logic freq_frz;
        logic force_tmo;
        logic force_eom;
        logic resume;
        logic next_cfg;
        logic fifo_init;
    } rmc_state_t;

    localparam rmc_state_t RMC_ST_RESET = '{
        mode: RMC_SLAVE,
        man_freeze: RMC_CMD_RESET[RMC_B_GAIN_FRZ:RMC_B_FREQ_FRZ],
        cfg: RMC_CFG_RESET[5:0],
        default: 1'b0
    };

    rmc_state_t st;
    rmc_state_t next_st;
    logic [1:0] hit;
    logic [31:0] rd_data;
    logic wr_go;
    logic wr_cmd;
    logic wr_cfg;
    logic ext_ok;
    logic eom_evt;
    logic tmo_evt;

    // Bus handshake
    rmc_apb_slave u_slave (
        .pclk(pclk),
        .presetn(presetn),
        .req(apb_req),
        .mapped(|hit),
        .rd_data(rd_data),
        .rsp(apb_rsp),
        .wr_go(wr_go)
    );

    // Decode, read-back and event qualifiers
    always_comb begin
        hit = rmc_decode(apb_req.paddr);
        wr_cmd = wr_go && hit[0] && apb_req.pstrb[0];
        wr_cfg = wr_go && hit[1] && apb_req.pstrb[0];
        ext_ok = (external_processing_select == RMC_EXT_SEL_A)
            || (external_processing_select == RMC_EXT_SEL_B);
        eom_evt = end_of_message_in || st.force_eom;
        tmo_evt = receive_timeout_in || st.force_tmo;
        rd_data = 32'h0000_0000;
        if (hit[0]) begin
            rd_data[RMC_B_GAIN_FRZ] = st.man_freeze[1];
            rd_data[RMC_B_FREQ_FRZ] = st.man_freeze[0];
        end else if (hit[1]) begin
            rd_data[5:0] = st.cfg & RMC_CFG_MASK[5:0];
        end
    end

    // Next-state logic of registers, sequencer and outputs
    always_comb begin
        next_st = st;
        next_st.force_tmo = 1'b0;
        next_st.force_eom = 1'b0;
        next_st.resume = 1'b0;
        next_st.fifo_init = 1'b0;
        // Command register: freeze bits stored, force bits pulse
        if (wr_cmd) begin
            next_st.man_freeze[1] = apb_req.pwdata[RMC_B_GAIN_FRZ];
            next_st.man_freeze[0] = apb_req.pwdata[RMC_B_FREQ_FRZ];
            next_st.force_tmo = apb_req.pwdata[RMC_B_FORCE_TMO] && ext_ok;
            next_st.force_eom = apb_req.pwdata[RMC_B_FORCE_EOM] && ext_ok;
        end
        if (wr_cfg) begin
            next_st.cfg = apb_req.pwdata[5:0] & RMC_CFG_MASK[5:0];
        end
        // Freeze outputs follow software bits only under software source
        next_st.gain_frz = gain_freeze_source_sw && st.man_freeze[1];
        next_st.freq_frz = freq_freeze_source_sw && st.man_freeze[0];
        // Mode sequencer
        case (st.mode)
            RMC_SLAVE: begin
                if (operating_mode_select) begin
                    next_st.mode = RMC_POLL;
                end else if (slave_run_start && st.cfg[RMC_B_CYC_INIT]) begin
                    next_st.fifo_init = 1'b1;
                end
            end
            RMC_POLL: begin
                if (!operating_mode_select) begin
                    next_st.mode = RMC_SLAVE;
                end else if (wakeup_found) begin
                    next_st.mode = RMC_RUN;
                    next_st.fifo_init = st.cfg[RMC_B_CYC_INIT];
                end
            end
            RMC_RUN: begin
                if (!operating_mode_select) begin
                    next_st.mode = RMC_SLAVE;
                end else if (eom_evt) begin
                    next_st.mode = RMC_POLL;
                    next_st.resume = 1'b1;
                    next_st.next_cfg = st.cfg[RMC_B_CONT_MSG];
                end else if (tmo_evt) begin
                    next_st.mode = RMC_POLL;
                    next_st.resume = 1'b1;
                    next_st.next_cfg = st.cfg[RMC_B_CONT_TMO];
                end
            end
            default: begin
                next_st.mode = RMC_SLAVE;
            end
        endcase
        // Frame start initialization
        if (frame_start && st.cfg[RMC_B_FRM_INIT]) begin
            next_st.fifo_init = 1'b1;
        end
        // Lock at message end; a new lock wins over a release
        if (eom_evt && st.cfg[RMC_B_LOCK]) begin
            next_st.fifo_locked = 1'b1;
        end else if (fifo_lock_release) begin
            next_st.fifo_locked = 1'b0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= RMC_ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops
    assign gain_freeze = st.gain_frz;
    assign freq_freeze = st.freq_frz;
    assign receive_timeout_force = st.force_tmo;
    assign end_of_message_force = st.force_eom;
    assign resume_poll = st.resume;
    assign resume_next_config = st.next_cfg;
    assign fifo_init = st.fifo_init;
    assign fifo_lock = st.fifo_locked;
    assign rx_chain_lock = st.fifo_locked;
    assign crystal_precision_in_sleep = st.cfg[RMC_B_XTAL];

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence cmd_write_s(int b);
        wr_cmd && apb_req.pwdata[b];
    endsequence

    sequence wake_entry_s;
        st.mode == RMC_POLL && operating_mode_select && wakeup_found;
    endsequence

    gain_freeze_set_a: assert property (
        cmd_write_s(RMC_B_GAIN_FRZ) ##1 gain_freeze_source_sw |=> gain_freeze)
        else $error("gain freeze not applied after software command");
    force_tmo_gate_a: assert property (
        receive_timeout_force |-> $past(wr_cmd) && $past(ext_ok))
        else $error("timeout forced without write or outside external mode");
    force_eom_go_a: assert property (
        cmd_write_s(RMC_B_FORCE_EOM) ##0 ext_ok |=> end_of_message_force ##1 !end_of_message_force)
        else $error("forced message end not a single pulse");
    resume_msg_a: assert property (
        st.mode == RMC_RUN && operating_mode_select && eom_evt
        |=> resume_poll && resume_next_config == $past(st.cfg[RMC_B_CONT_MSG])
            && st.mode == RMC_POLL)
        else $error("wrong resume after message end");
    resume_tmo_a: assert property (
        st.mode == RMC_RUN && operating_mode_select && !eom_evt && tmo_evt
        |=> resume_poll && resume_next_config == $past(st.cfg[RMC_B_CONT_TMO]))
        else $error("wrong resume after timeout");
    slave_init_a: assert property (
        st.mode == RMC_SLAVE && !operating_mode_select && slave_run_start
        && st.cfg[RMC_B_CYC_INIT] |=> fifo_init)
        else $error("fifo not initialized at slave run start");
    wake_init_a: assert property (
        wake_entry_s |=> st.mode == RMC_RUN && fifo_init == ($past(st.cfg[RMC_B_CYC_INIT])
            || ($past(frame_start) && $past(st.cfg[RMC_B_FRM_INIT]))))
        else $error("wake-up entry wrong");
    frame_init_a: assert property (
        frame_start && st.cfg[RMC_B_FRM_INIT] |=> fifo_init)
        else $error("fifo not initialized at frame start");
    lock_hold_a: assert property (
        fifo_lock && !fifo_lock_release |=> fifo_lock && rx_chain_lock)
        else $error("fifo lock dropped without release");
    mode_slave_a: assert property (
        !operating_mode_select [*2] |-> st.mode == RMC_SLAVE)
        else $error("sequencer not in slave mode");
    unused_read_a: assert property (
        apb_rsp.pready |-> apb_rsp.prdata[31:6] == 26'h0)
        else $error("unused bits read nonzero");
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Testbench: register access, command effects and polling sequencer checks
`default_nettype none
module tb import rmc_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk;
    logic presetn;
    rmc_apb_req_t req;
    rmc_apb_rsp_t rsp;
    logic mode_sel;
    logic gsrc;
    logic fsrc;
    logic [1:0] ext_sel;
    logic [5:0] ev;
    logic gain_frz, freq_frz, tmo_f, eom_f, rp, rnc, fi, lk, chain_lk, xtal;
    int cnt [4];
    int exp_cnt [4];
    int fail_count;
    int num_checks;
    logic [31:0] rd;
    logic err;

    // Design under test; event inputs come from the ev vector
    rmc_regs dut_u (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .operating_mode_select(mode_sel), .external_processing_select(ext_sel),
        .gain_freeze_source_sw(gsrc), .freq_freeze_source_sw(fsrc),
        .end_of_message_in(ev[0]), .receive_timeout_in(ev[1]), .wakeup_found(ev[2]),
        .slave_run_start(ev[3]), .frame_start(ev[4]), .fifo_lock_release(ev[5]),
        .gain_freeze(gain_frz), .freq_freeze(freq_frz), .receive_timeout_force(tmo_f),
        .end_of_message_force(eom_f), .resume_poll(rp), .resume_next_config(rnc),
        .fifo_init(fi), .fifo_lock(lk), .rx_chain_lock(chain_lk),
        .crystal_precision_in_sleep(xtal)
    );

    // Clock at 40 MHz
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Counts the one-cycle pulses of the design
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '{default: 0};
        end else begin
            cnt[0] <= cnt[0] + int'(tmo_f);
            cnt[1] <= cnt[1] + int'(eom_f);
            cnt[2] <= cnt[2] + int'(rp);
            cnt[3] <= cnt[3] + int'(fi);
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) @(posedge pclk);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // One-cycle event on input i, then time for the answer to land
    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic final_report();
        $display("Checks: %0d, mismatches: %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        final_report();
    end

    // Main sequence
    initial begin
        presetn = 1'b0;
        req = '0;
        req.pstrb = 4'hF;
        mode_sel = 1'b0;
        ext_sel = 2'h0;
        gsrc = 1'b0;
        fsrc = 1'b0;
        ev = '0;
        fail_count = 0;
        num_checks = 0;
        exp_cnt = '{default: 0};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, RMC_ADDR_CMD, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, RMC_ADDR_CFG, 32'h0);
        chk(rd, 32'h4);
        chk(xtal, 1'b0);
        apb(1'b0, 12'h298, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, RMC_ADDR_CFG, 32'hFFFFFFFF);
        apb(1'b0, RMC_ADDR_CFG, 32'h0);
        chk(rd, 32'h3F);
        chk(xtal, 1'b1);
        apb(1'b1, RMC_ADDR_CFG, 32'h2E);
        repeat (2) @(posedge pclk);
        chk(xtal, 1'b0);
        gsrc <= 1'b1;
        fsrc <= 1'b1;
        // Forcing is honoured only for selections 1 and 2
        for (int s = 0; s < 4; s++) begin
            ext_sel <= 2'(s);
            apb(1'b1, RMC_ADDR_CMD, 32'h3);
            repeat (3) @(posedge pclk);
            if (s == 1 || s == 2) begin
                exp_cnt[0]++;
                exp_cnt[1]++;
            end
            chk(cnt[0], exp_cnt[0]);
            chk(cnt[1], exp_cnt[1]);
        end
        apb(1'b1, RMC_ADDR_CMD, 32'h8);
        repeat (3) @(posedge pclk);
        chk({gain_frz, freq_frz}, 2'b10);
        apb(1'b0, RMC_ADDR_CMD, 32'h0);
        chk(rd, 32'h8);
        apb(1'b1, RMC_ADDR_CMD, 32'h4);
        repeat (3) @(posedge pclk);
        chk({gain_frz, freq_frz}, 2'b01);
        fsrc <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(freq_frz, 1'b0);
        // Slave mode: run start and frame start initialise the FIFO
        pulse(3);
        exp_cnt[3]++;
        chk(cnt[3], exp_cnt[3]);
        pulse(4);
        exp_cnt[3]++;
        chk(cnt[3], exp_cnt[3]);
        pulse(0);
        chk(cnt[2], exp_cnt[2]);
        pulse(5);
        // Self-polling: wake-up, message end with lock, next config
        mode_sel <= 1'b1;
        repeat (2) @(posedge pclk);
        pulse(2);
        exp_cnt[3]++;
        chk(cnt[3], exp_cnt[3]);
        pulse(0);
        exp_cnt[2]++;
        chk(cnt[2], exp_cnt[2]);
        chk({rnc, lk, chain_lk}, 3'b111);
        pulse(5);
        chk({lk, chain_lk}, 2'b00);
        apb(1'b1, RMC_ADDR_CFG, 32'h18);
        pulse(2);
        exp_cnt[3]++;
        chk(cnt[3], exp_cnt[3]);
        pulse(1);
        exp_cnt[2]++;
        chk(cnt[2], exp_cnt[2]);
        chk(rnc, 1'b1);
        pulse(4);
        chk(cnt[3], exp_cnt[3]);
        pulse(2);
        exp_cnt[3]++;
        pulse(0);
        exp_cnt[2]++;
        chk(cnt[2], exp_cnt[2]);
        chk({rnc, lk}, 2'b00);
        // Forced timeout in polling run resumes with the next configuration
        ext_sel <= 2'h1;
        pulse(2);
        exp_cnt[3]++;
        apb(1'b1, RMC_ADDR_CMD, 32'h2);
        repeat (3) @(posedge pclk);
        exp_cnt[0]++;
        exp_cnt[2]++;
        chk(cnt[0], exp_cnt[0]);
        chk(cnt[2], exp_cnt[2]);
        chk(rnc, 1'b1);
        // Select 0 returns the sequencer to slave run
        mode_sel <= 1'b0;
        pulse(3);
        exp_cnt[3]++;
        chk(cnt[3], exp_cnt[3]);
        // Reset in mid-run restores the register defaults
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, RMC_ADDR_CFG, 32'h0);
        chk(rd, 32'h4);
        chk(xtal, 1'b0);
        chk(lk, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
